/* File: verilog/cofc_pkg.sv */
// Purpose: Shared types and constants for the counter output fault control link
// Assumes: Two counter channels, four outputs, 32-bit count words
// Notes: Data sets travel as packed structs through cofc_link_if
package cofc_pkg;

    // ****************************************************************
    // Sizes and limits
    // ****************************************************************
    localparam int COFC_NCH = 2;
    localparam int COFC_NOUT = 4;
    localparam int COFC_CW = 32;
    localparam logic [COFC_CW-1:0] COFC_WRAP_MAX = 32'h00FF_FFFE;
    localparam logic [COFC_CW-1:0] COFC_ZERO = 32'h0000_0000;

    // ****************************************************************
    // Encodings
    // ****************************************************************
    typedef enum logic [2:0] {
        FN_COUNT = 3'h0,
        FN_QX1 = 3'h1,
        FN_QX4 = 3'h2,
        FN_UNUSED = 3'h3,
        FN_FREQ = 3'h4,
        FN_PERIOD = 3'h5,
        FN_CONT = 3'h6
    } cofc_func_e;

    typedef enum logic [2:0] {
        CAP_NONE = 3'h0,
        CAP_STORE = 3'h1,
        CAP_WAIT = 3'h2,
        CAP_RST_WAIT = 3'h3,
        CAP_RST_START = 3'h4
    } cofc_cap_e;

    typedef enum logic [1:0] {
        TIE_NONE = 2'h0,
        TIE_CH0 = 2'h1,
        TIE_CH1 = 2'h2
    } cofc_tie_e;

    typedef enum logic [1:0] {
        FS_HOLD = 2'h0,
        FS_OFF = 2'h1,
        FS_ON = 2'h2
    } cofc_fstate_e;

    typedef enum logic [1:0] {
        FC_NONE = 2'h0,
        FC_OFF = 2'h1,
        FC_ON = 2'h2
    } cofc_force_e;

    // ****************************************************************
    // Data sets
    // ****************************************************************
    typedef struct packed {
        cofc_func_e channel_function_select;
        cofc_cap_e capture_policy;
        logic [COFC_CW-1:0] wrap_limit;
        logic [COFC_CW-1:0] start_value;
    } cofc_chan_cfg_s;

    typedef struct packed {
        cofc_tie_e output_counter_tie;
        cofc_fstate_e output_fault_state;
        cofc_fstate_e output_prog_state;
        logic [COFC_CW-1:0] on_value;
        logic [COFC_CW-1:0] off_value;
    } cofc_out_cfg_s;

    typedef struct packed {
        logic prog_fault_select;
        cofc_chan_cfg_s [COFC_NCH-1:0] chan;
        cofc_out_cfg_s [COFC_NOUT-1:0] outp;
    } cofc_cfg_s;

    typedef struct packed {
        logic link_ok;
        logic prog_mode;
        cofc_force_e [COFC_NOUT-1:0] output_force_control;
        logic [COFC_NCH-1:0] wrap_ovr_en;
        logic [COFC_NCH-1:0][COFC_CW-1:0] wrap_ovr;
    } cofc_odata_s;

    typedef struct packed {
        logic configured;
        logic [COFC_NCH-1:0] held;
        logic [COFC_NOUT-1:0] out_state;
        logic [COFC_NCH-1:0][COFC_CW-1:0] present;
        logic [COFC_NCH-1:0][COFC_CW-1:0] stored;
    } cofc_idata_s;

endpackage : cofc_pkg

/* File: verilog/cofc_link_if.sv */
// Purpose: Link between supervising controller and counter device
// Assumes: Both ends share mclk_i; no crossing on the link
// Notes: cfg_valid is a one-cycle strobe qualifying cfg
`timescale 1ns/10ps
`default_nettype none
interface cofc_link_if;
    import cofc_pkg::*;

    logic cfg_valid;
    cofc_cfg_s cfg;
    cofc_odata_s odata;
    cofc_idata_s idata;

    modport dev (
        input cfg_valid,
        input cfg,
        input odata,
        output idata
    );

    modport ctrl (
        output cfg_valid,
        output cfg,
        output odata,
        input idata
    );

endinterface : cofc_link_if
`default_nettype wire

/* File: verilog/cofc_device.sv */
// Purpose: Two-channel pulse counter with four window-driven outputs
// Assumes: A, B, Z pins are asynchronous; link signals share mclk_i
// Notes:
// Functional notes
// - Capture policy zero never stores on index
// - No counting while wrap limit is zero
// - Frequency function never counts A/B pulses
// - Untied output never turns on by window
// - Fault state one turns output off
// - Program mode applies program state setting
// - Force value two drives output on
// - Force value one drives output off
// - Lost link in program: select picks state
// - Controller keeps wrap limit within range
// - Controller zeroes wrap in rate functions
// - Indicators follow A, B, Z, outputs
// - Configuration set defines behaviour on delivery
// - Output data set steers running behaviour
// - Input data set reports state continually
// - Two channels and four outputs replicated
// - Output data may override wrap limit
// - Channel function encoding zero to six
// - Capture policy encoding zero to four
// - Counting starts at the start value
`timescale 1ns/10ps
`default_nettype none
module cofc_device
    import cofc_pkg::*;
(
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    cofc_link_if.dev link,
    input wire logic [COFC_NCH-1:0] a_pin_i,
    input wire logic [COFC_NCH-1:0] b_pin_i,
    input wire logic [COFC_NCH-1:0] z_pin_i,
    output logic [COFC_NOUT-1:0] out_pin_o,
    output logic [COFC_NCH-1:0] led_a_o,
    output logic [COFC_NCH-1:0] led_b_o,
    output logic [COFC_NCH-1:0] led_z_o,
    output logic [COFC_NOUT-1:0] led_out_o
);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic in_window(input logic [COFC_CW-1:0] val,
                                       input logic [COFC_CW-1:0] lo,
                                       input logic [COFC_CW-1:0] hi);
        in_window = (val >= lo) && (val <= hi);
    endfunction : in_window

    function automatic logic apply_state(input cofc_fstate_e st, input logic cur);
        case (st)
            FS_OFF: apply_state = 1'b0;
            FS_ON: apply_state = 1'b1;
            default: apply_state = cur;
        endcase
    endfunction : apply_state

    // ****************************************************************
    // Configuration store
    // ****************************************************************
    cofc_cfg_s cfg_r;
    logic configured_r;

    // Held from delivery; zero wrap limits keep counters idle until then
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cfg_r <= '0;
            configured_r <= 1'b0;
        end else if (link.cfg_valid) begin
            cfg_r <= link.cfg;
            configured_r <= 1'b1;
        end
    end

    // Remember program mode so a later link loss knows where it stood
    logic prog_seen_r;

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            prog_seen_r <= 1'b0;
        end else if (link.odata.link_ok) begin
            prog_seen_r <= link.odata.prog_mode;
        end
    end

    // ****************************************************************
    // Counter channels
    // ****************************************************************
    logic [COFC_NCH-1:0][COFC_CW-1:0] present_w;
    logic [COFC_NCH-1:0][COFC_CW-1:0] stored_w;
    logic [COFC_NCH-1:0] held_w;
    logic [COFC_NCH-1:0][2:0] pin_w;

    for (genvar c = 0; c < COFC_NCH; c++) begin : g_ch
        logic [2:0] s1_r;
        logic [2:0] s2_r;
        logic [2:0] s3_r;
        logic [2:0] rise;
        logic [2:0] fall;
        logic step;
        logic up;
        logic [COFC_CW-1:0] wrap;
        logic [COFC_CW-1:0] start;
        logic [COFC_CW-1:0] cnt_r;
        logic [COFC_CW-1:0] stored_r;
        logic hold_r;

        // Two flops before use; s3 only serves edge detection
        always_ff @(posedge mclk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
                s1_r <= 3'h0;
                s2_r <= 3'h0;
                s3_r <= 3'h0;
            end else begin
                s1_r <= {z_pin_i[c], b_pin_i[c], a_pin_i[c]};
                s2_r <= s1_r;
                s3_r <= s2_r;
            end
        end

        assign rise = s2_r & ~s3_r;
        assign fall = ~s2_r & s3_r;
        assign start = cfg_r.chan[c].start_value;
        assign wrap = link.odata.wrap_ovr_en[c] ? link.odata.wrap_ovr[c]
                                                : cfg_r.chan[c].wrap_limit;

        always_comb begin
            step = 1'b0;
            up = 1'b0;
            case (cfg_r.chan[c].channel_function_select)
                FN_COUNT, FN_QX1: begin
                    step = rise[0];
                    up = ~s2_r[1];
                end
                FN_QX4: begin
                    step = |(rise[1:0] | fall[1:0]);
                    up = (rise[0] & ~s2_r[1]) | (fall[0] & s2_r[1])
                       | (rise[1] & s2_r[0]) | (fall[1] & ~s2_r[0]);
                end
                default: begin
                    step = 1'b0;
                    up = 1'b0;
                end
            endcase
        end

        // Index takes priority when capture policy is not zero; a pulse landing on the same edge is then dropped
        always_ff @(posedge mclk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
                cnt_r <= '0;
                stored_r <= '0;
                hold_r <= 1'b0;
            end else if (link.cfg_valid) begin
                cnt_r <= link.cfg.chan[c].start_value;
                hold_r <= 1'b0;
            end else if (rise[2] && cfg_r.chan[c].capture_policy != CAP_NONE) begin
                case (cfg_r.chan[c].capture_policy)
                    CAP_STORE: begin
                        stored_r <= cnt_r;
                    end
                    CAP_WAIT: begin
                        if (hold_r) begin
                            hold_r <= 1'b0;
                        end else begin
                            stored_r <= cnt_r;
                            hold_r <= 1'b1;
                        end
                    end
                    CAP_RST_WAIT: begin
                        if (hold_r) begin
                            hold_r <= 1'b0;
                        end else begin
                            stored_r <= cnt_r;
                            cnt_r <= start;
                            hold_r <= 1'b1;
                        end
                    end
                    CAP_RST_START: begin
                        stored_r <= cnt_r;
                        cnt_r <= start;
                    end
                    default: begin
                        hold_r <= hold_r;
                    end
                endcase
            end else if (step && (wrap != COFC_ZERO) && !hold_r) begin
                if (up) begin
                    cnt_r <= (cnt_r >= wrap) ? start : cnt_r + 32'h0000_0001;
                end else begin
                    cnt_r <= (cnt_r <= start) ? wrap : cnt_r - 32'h0000_0001;
                end
            end
        end

        assign present_w[c] = cnt_r;
        assign stored_w[c] = stored_r;
        assign held_w[c] = hold_r;
        assign pin_w[c] = s2_r;
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    logic [COFC_NOUT-1:0] out_r;

    for (genvar o = 0; o < COFC_NOUT; o++) begin : g_out
        cofc_out_cfg_s oc;
        logic [COFC_CW-1:0] tied_val;
        logic win;
        logic run_lvl;
        logic nxt;
        logic lvl_r;

        assign oc = cfg_r.outp[o];
        assign tied_val = (oc.output_counter_tie == TIE_CH1) ? present_w[1] : present_w[0];
        assign win = (oc.output_counter_tie != TIE_NONE)
                   && in_window(tied_val, oc.on_value, oc.off_value);

        always_comb begin
            case (link.odata.output_force_control[o])
                FC_ON: run_lvl = 1'b1;
                FC_OFF: run_lvl = 1'b0;
                default: run_lvl = win;
            endcase
            // Loss of link outranks everything the controller last asked for
            if (!link.odata.link_ok) begin
                if (prog_seen_r && !cfg_r.prog_fault_select) begin
                    nxt = apply_state(oc.output_prog_state, out_r[o]);
                end else begin
                    nxt = apply_state(oc.output_fault_state, out_r[o]);
                end
            end else if (link.odata.prog_mode) begin
                nxt = apply_state(oc.output_prog_state, out_r[o]);
            end else begin
                nxt = run_lvl;
            end
        end

        always_ff @(posedge mclk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
                lvl_r <= 1'b0;
            end else begin
                lvl_r <= nxt;
            end
        end

        // One flop per output, so no two processes write the same vector
        assign out_r[o] = lvl_r;
    end

    assign out_pin_o = out_r;

    // ****************************************************************
    // Indicators and input data set
    // ****************************************************************
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            led_a_o <= '0;
            led_b_o <= '0;
            led_z_o <= '0;
            led_out_o <= '0;
        end else begin
            for (int c = 0; c < COFC_NCH; c++) begin
                led_a_o[c] <= pin_w[c][0];
                led_b_o[c] <= pin_w[c][1];
                led_z_o[c] <= pin_w[c][2];
            end
            led_out_o <= out_r;
        end
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            link.idata <= '0;
        end else begin
            link.idata.configured <= configured_r;
            link.idata.held <= held_w;
            link.idata.out_state <= out_r;
            link.idata.present <= present_w;
            link.idata.stored <= stored_w;
        end
    end

endmodule : cofc_device
`default_nettype wire

/* File: verilog/cofc_ctrl.sv */
// Purpose: Supervising controller end of the counter link
// Assumes: Same mclk_i as the device
// Notes: Sends configuration once after reset and on each reconfigure pulse
`timescale 1ns/10ps
`default_nettype none
module cofc_ctrl
    import cofc_pkg::*;
(
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    cofc_link_if.ctrl link,
    input wire logic reconfig_i,
    input wire cofc_cfg_s cfg_i,
    input wire logic conn_ok_i,
    input wire logic prog_mode_i,
    input wire cofc_force_e [COFC_NOUT-1:0] force_i,
    input wire logic [COFC_NCH-1:0] wrap_ovr_en_i,
    input wire logic [COFC_NCH-1:0][COFC_CW-1:0] wrap_ovr_i,
    output cofc_idata_s status_o
);

    // ****************************************************************
    // Configuration sanitising
    // ****************************************************************
    function automatic logic rate_fn(input cofc_func_e f);
        rate_fn = (f == FN_PERIOD) || (f == FN_CONT);
    endfunction : rate_fn

    // Out-of-range limits are clamped rather than sent, so the device never sees them
    function automatic logic [COFC_CW-1:0] clamp_wrap(input cofc_func_e f,
                                                      input logic [COFC_CW-1:0] w);
        if (rate_fn(f)) begin
            clamp_wrap = COFC_ZERO;
        end else if (w > COFC_WRAP_MAX) begin
            clamp_wrap = COFC_WRAP_MAX;
        end else begin
            clamp_wrap = w;
        end
    endfunction : clamp_wrap

    cofc_cfg_s cfg_clean;

    always_comb begin
        cfg_clean = cfg_i;
        for (int c = 0; c < COFC_NCH; c++) begin
            cfg_clean.chan[c].wrap_limit = clamp_wrap(cfg_i.chan[c].channel_function_select,
                                                      cfg_i.chan[c].wrap_limit);
            if (rate_fn(cfg_i.chan[c].channel_function_select)
                || cfg_i.chan[c].start_value >= cfg_clean.chan[c].wrap_limit) begin
                cfg_clean.chan[c].start_value = COFC_ZERO;
            end
        end
    end

    // ****************************************************************
    // Configuration delivery
    // ****************************************************************
    logic powered_r;

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            powered_r <= 1'b0;
            link.cfg_valid <= 1'b0;
            link.cfg <= '0;
        end else begin
            powered_r <= 1'b1;
            link.cfg_valid <= !powered_r || reconfig_i;
            if (!powered_r || reconfig_i) begin
                link.cfg <= cfg_clean;
            end
        end
    end

    // ****************************************************************
    // Output data set, every cycle
    // ****************************************************************
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            link.odata <= '0;
        end else begin
            link.odata.link_ok <= conn_ok_i;
            link.odata.prog_mode <= prog_mode_i;
            link.odata.output_force_control <= force_i;
            link.odata.wrap_ovr_en <= wrap_ovr_en_i;
            for (int c = 0; c < COFC_NCH; c++) begin
                link.odata.wrap_ovr[c] <= clamp_wrap(link.cfg.chan[c].channel_function_select,
                                                     wrap_ovr_i[c]);
            end
        end
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            status_o <= '0;
        end else begin
            status_o <= link.idata;
        end
    end

endmodule : cofc_ctrl
`default_nettype wire

/* File: verification/cofc_link_properties.sv */
// Purpose: Link checker for the controller and device ends
// Assumes: One clock domain, reset asynchronous active high
// Notes: Sees only the link signals
`timescale 1ns/10ps
`default_nettype none
module cofc_link_chk
    import cofc_pkg::*;
(
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic cfg_valid,
    input wire cofc_cfg_s cfg,
    input wire cofc_odata_s odata,
    input wire cofc_idata_s idata
);
    default clocking dc @(posedge mclk_i);
    endclocking
    default disable iff (sys_rst_i);

    // ********
    // Configuration and counting
    // ********
    cfg_done_a : assert property (cfg_valid |-> ##2 idata.configured)
        else $error("configured flag late");
    no_store_a : assert property ((!cfg_valid && cfg.chan[0].capture_policy == CAP_NONE)[*3]
        |=> $stable(idata.stored[0])) else $error("stored count moved without capture");
    no_wrap_a : assert property ((!cfg_valid && cfg.chan[0].wrap_limit == COFC_ZERO
        && cfg.chan[0].channel_function_select == FN_COUNT && !odata.wrap_ovr_en[0])[*3]
        |=> $stable(idata.present[0])) else $error("counted with zero wrap");
    freq_hold_a : assert property ((!cfg_valid
        && cfg.chan[0].channel_function_select == FN_FREQ)[*3]
        |=> $stable(idata.present[0])) else $error("counted in frequency function");

    // ********
    // Output levels; settled state needs two link cycles
    // ********
    force_on_a : assert property ((odata.link_ok && !odata.prog_mode
        && odata.output_force_control[1] == FC_ON)[*2] |=> idata.out_state[1])
        else $error("forced output not on");
    force_off_a : assert property ((odata.link_ok && !odata.prog_mode
        && odata.output_force_control[0] == FC_OFF)[*2] |=> !idata.out_state[0])
        else $error("forced output not off");
    untied_off_a : assert property ((odata.link_ok && !odata.prog_mode && !cfg_valid
        && odata.output_force_control[1] == FC_NONE
        && cfg.outp[1].output_counter_tie == TIE_NONE)[*2] |=> !idata.out_state[1])
        else $error("untied output on");
    fault_off_a : assert property ((!odata.link_ok && cfg.prog_fault_select && !cfg_valid
        && cfg.outp[0].output_fault_state == FS_OFF)[*2] |=> !idata.out_state[0])
        else $error("output on during fault");
    prog_off_a : assert property ((odata.link_ok && odata.prog_mode && !cfg_valid
        && cfg.outp[0].output_prog_state == FS_OFF)[*2] |=> !idata.out_state[0])
        else $error("output on in program mode");
    lost_prog_a : assert property (odata.link_ok && odata.prog_mode
        ##1 (!odata.link_ok && !cfg.prog_fault_select && !cfg_valid
        && cfg.outp[3].output_prog_state == FS_ON)[*2] |=> idata.out_state[3])
        else $error("lost link ignored program setting");
endmodule : cofc_link_chk
`default_nettype wire

/* File: verification/counter_output_fault_control_tb.sv */
// Purpose: End-to-end bench for controller and device
// Assumes: Both ends on mclk_i at 40 MHz
// Notes: Scenarios run in order and share counter state
`timescale 1ns/10ps
`default_nettype none
module counter_output_fault_control_tb;
    import cofc_pkg::*;

    // ********
    // Stimulus and observation
    // ********
    logic mclk_i = 1'h0;
    logic sys_rst_i = 1'h1;
    logic reconfig = 1'h0;
    logic conn = 1'h1;
    logic prog = 1'h0;
    cofc_cfg_s cfg_i;
    cofc_force_e [COFC_NOUT-1:0] frc;
    logic [COFC_NCH-1:0] ovr_en = '0;
    logic [COFC_NCH-1:0][COFC_CW-1:0] ovr = '0;
    logic [2:0][COFC_NCH-1:0] pin = '0;
    logic [2:0][COFC_NCH-1:0] led;
    logic [COFC_NOUT-1:0] opin;
    logic [COFC_NOUT-1:0] led_out;
    cofc_idata_s st;
    int mismatches = 0;
    int cmp_count = 0;

    always #12.5 mclk_i = ~mclk_i;

    cofc_link_if lnk ();
    cofc_ctrl cofc_ctrl_inst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .link(lnk.ctrl),
        .reconfig_i(reconfig), .cfg_i(cfg_i), .conn_ok_i(conn), .prog_mode_i(prog),
        .force_i(frc), .wrap_ovr_en_i(ovr_en), .wrap_ovr_i(ovr), .status_o(st));
    cofc_device cofc_device_inst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .link(lnk.dev),
        .a_pin_i(pin[0]), .b_pin_i(pin[1]), .z_pin_i(pin[2]), .out_pin_o(opin),
        .led_a_o(led[0]), .led_b_o(led[1]), .led_z_o(led[2]), .led_out_o(led_out));
    cofc_link_chk cofc_link_chk_inst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
        .cfg_valid(lnk.cfg_valid), .cfg(lnk.cfg), .odata(lnk.odata), .idata(lnk.idata));

    // ********
    // Helpers
    // ********
    task chk(input logic [COFC_CW-1:0] got, input logic [COFC_CW-1:0] exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: %s got %0h expected %0h", $time, m, got, exp);
        end
    endtask : chk

    // Returns off the edge so outputs have settled
    task wt(input int n);
        repeat (n) @(posedge mclk_i);
        @(negedge mclk_i);
    endtask : wt

    // Four cycles high, four low: above the two-flop minimum
    task pulse(input int p, input int c);
        @(posedge mclk_i);
        pin[p][c] <= 1'h1;
        wt(3);
        chk(led[p][c], 1'h1, "input lit");
        @(posedge mclk_i);
        pin[p][c] <= 1'h0;
        wt(3);
        chk(led[p][c], 1'h0, "input dark");
    endtask : pulse

    // Called at a rising edge
    task rcfg();
        reconfig <= 1'h1;
        @(posedge mclk_i);
        reconfig <= 1'h0;
        wt(6);
    endtask : rcfg

    task outs(input logic [3:0] e);
        chk(opin, e, "outputs");
        chk(st.out_state, e, "reported outputs");
        chk(led_out, e, "output leds");
    endtask : outs

    task end_sim();
        $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim

    // ********
    // Scenarios
    // ********
    task t_reset();
        wt(6);
        chk(st.configured, 1'h1, "configured");
        chk(st.present[0], 32'h3, "start value");
        chk(lnk.cfg.chan[1].wrap_limit, 32'h0, "rate wrap");
        chk(lnk.cfg.chan[1].start_value, 32'h0, "rate start");
        outs(4'h0);
    endtask : t_reset

    task t_count();
        pulse(1, 0);
        pulse(1, 1);
        pulse(2, 1);
        pulse(0, 0);
        chk(st.present[0], 32'h4, "count up");
        outs(4'h1);
        @(posedge mclk_i);
        frc[0] <= FC_OFF;
        wt(5);
        outs(4'h0);
        @(posedge mclk_i);
        frc[0] <= FC_NONE;
        frc[1] <= FC_ON;
        wt(5);
        outs(4'h3);
        @(posedge mclk_i);
        frc[1] <= FC_NONE;
        repeat (7) pulse(0, 0);
        chk(st.present[0], 32'h3, "wrap to start");
    endtask : t_count

    task t_out();
        pulse(0, 0);
        @(posedge mclk_i);
        prog <= 1'h1;
        wt(5);
        outs(4'h8);
        @(posedge mclk_i);
        conn <= 1'h0;
        wt(5);
        outs(4'h8);
        @(posedge mclk_i);
        conn <= 1'h1;
        prog <= 1'h0;
        wt(5);
        outs(4'h1);
        @(posedge mclk_i);
        conn <= 1'h0;
        wt(5);
        outs(4'h4);
        @(posedge mclk_i);
        conn <= 1'h1;
        prog <= 1'h1;
        cfg_i.prog_fault_select <= 1'h1;
        rcfg();
        @(posedge mclk_i);
        conn <= 1'h0;
        wt(5);
        outs(4'hC);
        @(posedge mclk_i);
        conn <= 1'h1;
        prog <= 1'h0;
    endtask : t_out

    task t_func();
        for (int f = 0; f < 7; f++) begin
            @(posedge mclk_i);
            cfg_i.chan[0].channel_function_select <= cofc_func_e'(f);
            rcfg();
            pulse(0, 0);
            // Quadrature x4 steps back on the A fall, which lands two cycles later
            wt(2);
            chk(st.present[0], (f < 2) ? 4 : (f > 4) ? 0 : 3, "function");
        end
        @(posedge mclk_i);
        cfg_i.chan[0].channel_function_select <= FN_COUNT;
        cfg_i.chan[0].wrap_limit <= 32'h0;
        cfg_i.chan[1].channel_function_select <= FN_COUNT;
        cfg_i.chan[1].wrap_limit <= 32'h0100_0000;
        rcfg();
        chk(lnk.cfg.chan[1].wrap_limit, COFC_WRAP_MAX, "wrap clamp");
        pulse(0, 0);
        chk(st.present[0], 32'h0, "zero wrap");
        pulse(0, 1);
        chk(st.present[1], 32'h3, "second channel");
        @(posedge mclk_i);
        ovr_en[0] <= 1'h1;
        ovr[0] <= 32'h0000_000A;
        pulse(0, 0);
        chk(st.present[0], 32'h1, "wrap override");
        @(posedge mclk_i);
        ovr_en[0] <= 1'h0;
    endtask : t_func

    task t_pol();
        int ea [5] = '{6, 6, 5, 3, 4};
        logic [COFC_CW-1:0] s0;
        for (int p = 0; p < 5; p++) begin
            @(posedge mclk_i);
            cfg_i.chan[0].wrap_limit <= 32'h0000_000A;
            cfg_i.chan[0].capture_policy <= cofc_cap_e'(p);
            rcfg();
            s0 = st.stored[0];
            repeat (2) pulse(0, 0);
            pulse(2, 0);
            chk(st.stored[0], (p == 0) ? s0 : 32'h5, "capture");
            chk(st.present[0], (p > 2) ? 32'h3 : 32'h5, "after index");
            chk(st.held[0], (p == 2 || p == 3) ? 32'h1 : 32'h0, "held");
            pulse(0, 0);
            chk(st.present[0], ea[p], "after index count");
        end
    endtask : t_pol

    // ********
    // Main sequence and watchdog
    // ********
    initial begin
        foreach (frc[i]) frc[i] = FC_NONE;
        cfg_i = '0;
        cfg_i.chan[0].wrap_limit = 32'h0000_000A;
        cfg_i.chan[0].start_value = 32'h0000_0003;
        cfg_i.chan[1].channel_function_select = FN_PERIOD;
        cfg_i.chan[1].wrap_limit = 32'h0000_0007;
        cfg_i.chan[1].start_value = 32'h0000_0002;
        cfg_i.outp[0] = '{TIE_CH0, FS_OFF, FS_OFF, 32'h4, 32'h6};
        cfg_i.outp[1] = '{TIE_NONE, FS_HOLD, FS_HOLD, 32'h0, COFC_WRAP_MAX};
        cfg_i.outp[2] = '{TIE_NONE, FS_ON, FS_OFF, 32'h0, 32'h0};
        cfg_i.outp[3] = '{TIE_NONE, FS_HOLD, FS_ON, 32'h0, 32'h0};
        repeat (10) @(posedge mclk_i);
        sys_rst_i <= 1'h0;
        t_reset();
        t_count();
        t_out();
        t_func();
        t_pol();
        end_sim();
    end

    // Run needs about 530 cycles
    initial begin
        #(25 * 6000);
        mismatches++;
        $display("Error at %0t: watchdog expired", $time);
        end_sim();
    end
endmodule : counter_output_fault_control_tb
`default_nettype wire
